/* dv/ddl_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Controller model: one command per frame
module ddl_ctrl_model (
    input  wire logic        mclk_i,    // Block clock
    input  wire logic        dq_oe_i,   // Read drive
    input  wire logic [7:0]  dq_i,      // Read data
    output logic             mem_clk_o, // Link clock
    output logic             cke_o,     // Clock enable
    output logic             term_o,    // Termination pin
    output logic      [2:0]  cmd_o,     // Command
    output logic      [1:0]  ba_o,      // Register select
    output logic      [12:0] addr_o,    // Mode value
    output logic      [7:0]  wdata_o    // Write data
);
    logic       oe_seen; // Drive at frame end
    logic [7:0] dq_seen; // Data at frame end
    // Link clock stands low outside frames
    initial
    begin
        {mem_clk_o, cke_o, term_o} = 3'b010;
        {cmd_o, ba_o, addr_o, wdata_o} = 26'h0;
    end
    // Level pins, changed just after a block clock edge
    task automatic pins(input logic k, input logic t);
        @(posedge mclk_i);
        cke_o  <= k; // Clock enable level
        term_o <= t; // Termination level
    endtask : pins
    // One 320 ns frame: setup half, rising edge, hold half
    task automatic frame(input logic [2:0] c, input logic [1:0] b,
                         input logic [12:0] a, input logic [7:0] w);
        @(posedge mclk_i);
        {cmd_o, ba_o, addr_o, wdata_o} <= {c, b, a, w};
        // Low 160 ns including the edge that ended the last frame
        repeat (3) @(posedge mclk_i);
        mem_clk_o <= 1'b1;
        repeat (4) @(posedge mclk_i);
        oe_seen = dq_oe_i;
        dq_seen = dq_i;
        mem_clk_o <= 1'b0;
        // Hold over: lines show the inverse, not the last value
        {cmd_o, ba_o, addr_o, wdata_o} <= ~{c, b, a, w};
    endtask : frame
endmodule : ddl_ctrl_model
`default_nettype wire

/* dv/ddl_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ddl_cfg.svh"
// ==========================================
// Bench: APB master, controller model, checks
module ddl_top_test;
    import ddl_pkg::*;
    logic        mclk, rst, psel, penable, pwrite; // Clock, reset, APB
    logic [7:0]  paddr;            // APB address
    logic [31:0] pwdata, prdata, q; // APB data
    logic        pready, pslverr, e; // APB answer
    logic        mck, cke, term, dq_oe, term_on; // Pins
    logic [2:0]  cmd;              // Command code
    logic [1:0]  ba;               // Register select
    logic [12:0] addr;             // Mode value
    logic [7:0]  wdata, dq;        // Data pins
    ddl_state_t  state;            // Power state
    int          failures, comparisons, seed, stored, hold;
    int          cl, al, off, v, w, n, i; // Reference model values
    int          exp_q[$];         // Expected read data
    ddl_top dut_u (.mclk_i(mclk), .reset_i(rst), .mem_clk_i(mck),
        .cke_i(cke), .termination_control_i(term), .cmd_i(cmd),
        .ba_i(ba), .addr_i(addr), .wdata_i(wdata), .dq_o(dq),
        .dq_oe_o(dq_oe), .term_on_o(term_on), .state_o(state),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr));
    ddl_ctrl_model ctl_u (.mclk_i(mclk), .dq_oe_i(dq_oe), .dq_i(dq),
        .mem_clk_o(mck), .cke_o(cke), .term_o(term), .cmd_o(cmd),
        .ba_o(ba), .addr_o(addr), .wdata_o(wdata));
    // Compare and count
    task automatic chk(input string s, input logic [31:0] x,
                       input logic [31:0] y);
        comparisons++;
        if (y !== x)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", s, x, y);
        end
    endtask : chk
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    // A bound ran out
    task automatic give_up();
        failures++;
        summarize();
    endtask : give_up
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
            give_up();
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // Mode write, then two idle frames as set delay
    task automatic mode_register_write(input logic [1:0] b, input logic [12:0] a);
        ctl_u.frame(`DDL_C_MRS, b, a, 8'h0);
        repeat (2) ctl_u.frame(`DDL_C_NOP, 2'h0, 13'h0, 8'h0);
    endtask : mode_register_write
    // Read, then count frames until drive shows
    task automatic rd(input int lat);
        exp_q.push_back(stored);
        ctl_u.frame(`DDL_C_READ, 2'h0, 13'h0, 8'h0);
        for (n = 1; n < 40; n++)
        begin
            ctl_u.frame(`DDL_C_NOP, 2'h0, 13'h0, 8'h0);
            if (ctl_u.oe_seen === 1'b1)
                break;
        end
        if (n == 40)
            give_up();
        chk("read latency", lat, n);
        chk("read data", exp_q.pop_front(), ctl_u.dq_seen);
    endtask : rd
    // Block clock, 40 ns
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Overall bound
    initial
    begin
        repeat (100000) @(posedge mclk);
        give_up();
    end
    // Main sequence
    initial
    begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {failures, comparisons, seed} = {32'h0, 32'h0, 32'hb998};
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b0, `DDL_A_CONFIG, 32'h0);
        chk("config reset", 32'h5, q);
        apb(1'b0, `DDL_A_STATUS, 32'h0);
        chk("status reset", 32'h5500, q & 32'hffef);
        apb(1'b1, `DDL_A_MODE0, 32'h1fff);
        apb(1'b0, `DDL_A_MODE0, 32'h0);
        chk("mode zero read only", 32'h0, q);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 32'h1, e);
        hold = 2 + ($unsigned($random(seed)) % 4);
        apb(1'b1, `DDL_A_CONFIG, hold);
        apb(1'b0, `DDL_A_CONFIG, 32'h0);
        chk("config", hold, q);
        $display("test registers done");
        stored = $random(seed) & 8'hff;
        ctl_u.frame(`DDL_C_WRITE, 2'h0, 13'h0, 8'(stored));
        for (i = 0; i < 6; i++)
        begin
            off = i / 3;
            v = $unsigned($random(seed)) % 3;
            w = $unsigned($random(seed)) % 3;
            mode_register_write(2'h0, 13'(v << 4));
            mode_register_write(2'h2, 13'(w << 3));
            mode_register_write(2'h1, 13'(off | ((i % 3) << 3)));
            cl = off ? 6 : 5 + v;
            al = (i % 3 == 1) ? cl - 1 : (i % 3 == 2) ? cl - 2 : 0;
            apb(1'b0, `DDL_A_STATUS, 32'h0);
            chk("status", ((off ? 6 : 5 + w) << 12) | (cl << 8) | (off << 2),
                q & 32'hffef);
            rd(al + cl - off);
        end
        $display("test latencies done");
        mode_register_write(2'h1, 13'h4);
        ctl_u.pins(1'b1, 1'b1);
        repeat (8) @(posedge mclk);
        chk("termination on", 32'h1, term_on);
        mode_register_write(2'h1, 13'h5);
        chk("termination loop off", 32'h0, term_on);
        ctl_u.pins(1'b1, 1'b0);
        mode_register_write(2'h1, 13'h0);
        $display("test termination done");
        ctl_u.frame(`DDL_C_SRE, 2'h0, 13'h0, 8'h0);
        chk("self refresh state", DDL_SR, state);
        ctl_u.pins(1'b0, 1'b0);
        for (n = 1; n < 40; n++)
        begin
            ctl_u.frame(`DDL_C_NOP, 2'h0, 13'h0, 8'h0);
            apb(1'b0, `DDL_A_STATUS, 32'h0);
            if (q[3] === 1'b1)
                break;
        end
        if (n == 40)
            give_up();
        chk("hold edges", hold, n);
        repeat (400) @(posedge mclk);
        ctl_u.frame(`DDL_C_WRITE, 2'h0, 13'h0, ~8'(stored));
        ctl_u.pins(1'b1, 1'b0);
        repeat (8) @(posedge mclk);
        chk("self refresh exit", DDL_IDLE, state);
        rd(5 + v);
        $display("test self refresh done");
        ctl_u.pins(1'b0, 1'b0);
        ctl_u.frame(`DDL_C_NOP, 2'h0, 13'h0, 8'h0);
        chk("power down state", DDL_PD, state);
        ctl_u.frame(`DDL_C_WRITE, 2'h0, 13'h0, ~8'(stored));
        ctl_u.pins(1'b1, 1'b0);
        ctl_u.frame(`DDL_C_NOP, 2'h0, 13'h0, 8'h0);
        chk("power down exit", DDL_IDLE, state);
        rd(5 + v);
        $display("test power down done");
        ctl_u.frame(`DDL_C_MRS, 2'h0, 13'(32'h100 | (v << 4)), 8'h0);
        apb(1'b0, `DDL_A_MODE0, 32'h0);
        chk("loop reset self clear", v << 4, q);
        for (n = 0; n < 600; n++)
        begin
            apb(1'b0, `DDL_A_STATUS, 32'h0);
            if (q[4] === 1'b1)
                break;
            ctl_u.frame(`DDL_C_NOP, 2'h0, 13'h0, 8'h0);
        end
        if (n == 600)
            give_up();
        chk("lock edges", 512, n);
        ctl_u.frame(`DDL_C_CAL, 2'h0, 13'h0, 8'h0);
        stored = $random(seed) & 8'hff;
        ctl_u.frame(`DDL_C_WRITE, 2'h0, 13'h0, 8'(stored));
        rd(5 + v);
        $display("test loop lock done");
        summarize();
    end
endmodule : ddl_top_test
`default_nettype wire

/* logic/ddl_cfg.svh */
// Operation
// - Self refresh keeps stored data without clock
// - Loop off: only latencies six and six
// - Loop off: strobe window starts one earlier
// - After entry hold, input clock ignored
`ifndef DDL_CFG_SVH
`define DDL_CFG_SVH
// =====================================================
// Register map (byte addresses)
`define DDL_A_STATUS   8'h00
`define DDL_A_MODE0    8'h04
`define DDL_A_MODE1    8'h08
`define DDL_A_MODE2    8'h0c
`define DDL_A_CONFIG   8'h10
// =====================================================
// Command codes on the command pins
`define DDL_C_NOP      3'h0
`define DDL_C_MRS      3'h1
`define DDL_C_SRE      3'h2
`define DDL_C_READ     3'h3
`define DDL_C_WRITE    3'h4
`define DDL_C_CAL      3'h5
// =====================================================
// Field positions and fixed values
`define DDL_MR1_LOOP_OFF  0
`define DDL_MR0_LOOP_RST  8
`define DDL_MR0_CL_LSB    4
`define DDL_MR1_AL_LSB    3
`define DDL_MR1_RTT_B0    2
`define DDL_MR1_RTT_B1    6
`define DDL_MR1_RTT_B2    9
`define DDL_MR2_CWL_LSB   3
`define DDL_LAT_BASE      4'h5
`define DDL_LAT_OFF       4'h6
`define DDL_HOLD_RST      8'h05
`define DDL_LOCK_CYC      10'h200
`endif

/* logic/ddl_pkg.sv */
package ddl_pkg;
    // Device power state
    typedef enum logic [1:0] {
        DDL_IDLE = 2'b00,
        DDL_SR   = 2'b01,
        DDL_PD   = 2'b10
    } ddl_state_t;
    // Two-stage synchroniser state
    typedef struct packed {
        logic [28:0] s1;
        logic [28:0] s2;
    } ddl_sync_t;
    // Whole device state
    typedef struct packed {
        ddl_state_t  state;
        logic [7:0]  hold_cnt;
        logic        ign_clk;
        logic [12:0] mr0;
        logic [12:0] mr1;
        logic [12:0] mr2;
        logic [7:0]  stored;
        logic [4:0]  rd_cnt;
        logic        rd_busy;
        logic [7:0]  dq;
        logic        dq_oe;
        logic [9:0]  lock_cnt;
        logic        locked;
        logic        term_on;
        logic        prev_clk;
        logic [31:0] prdata;
        logic        pslverr;
        logic [7:0]  cfg_hold;
    } ddl_reg_t;
endpackage : ddl_pkg

/* logic/ddl_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module ddl_sync
    import ddl_pkg::*;
(
    input  wire logic        mclk_i,   // Block clock
    input  wire logic        reset_i,  // Sync reset
    input  wire logic [28:0] async_i,  // Pins from outside
    output logic      [28:0] sync_o    // Synchronised copy
);
    ddl_sync_t st;       // Registered stages
    ddl_sync_t next_st;  // Next stages

    // =====================================================
    // Stage chain
    always_comb
    begin
        next_st.s1 = async_i;
        next_st.s2 = st.s1;
    end

    // Register both stages
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign sync_o = st.s2;
endmodule : ddl_sync
`default_nettype wire

/* logic/ddl_top.sv */
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ddl_cfg.svh"
module ddl_top (
    input  wire logic        mclk_i,     // Block clock 25 MHz
    input  wire logic        reset_i,    // Sync reset, high
    input  wire logic        mem_clk_i,  // Command clock pin
    input  wire logic        cke_i,      // Clock enable pin
    input  wire logic        termination_control_i, // Term pin
    input  wire logic [2:0]  cmd_i,      // Command code
    input  wire logic [1:0]  ba_i,       // Mode register select
    input  wire logic [12:0] addr_i,     // Address / mode value
    input  wire logic [7:0]  wdata_i,    // Write data
    output logic      [7:0]  dq_o,       // Read data
    output logic             dq_oe_o,    // Read data drive
    output logic             term_on_o,  // Termination active
    output ddl_pkg::ddl_state_t state_o, // Power state
    input  wire logic        psel_i,     // APB select
    input  wire logic        penable_i,  // APB enable
    input  wire logic        pwrite_i,   // APB direction
    input  wire logic [7:0]  paddr_i,    // APB address
    input  wire logic [31:0] pwdata_i,   // APB write data
    output logic      [31:0] prdata_o,   // APB read data
    output logic             pready_o,   // APB ready
    output logic             pslverr_o   // APB error
);
    import ddl_pkg::*;

    logic [28:0] pins;        // Synchronised pins
    ddl_reg_t    st;          // Registered state
    ddl_reg_t    next_st;     // Next state
    logic        clk_s;       // Synced command clock
    logic        cke_s;       // Synced clock enable
    logic        odt_s;       // Synced termination pin
    logic [2:0]  cmd_s;       // Synced command
    logic [1:0]  ba_s;        // Synced register select
    logic [12:0] addr_s;      // Synced address
    logic [7:0]  wdat_s;      // Synced write data
    logic        edge_r;      // Command clock rising edge
    logic        live;        // Edge that the device acts on
    logic        loop_off;    // Loop disabled
    logic [3:0]  eff_cl;      // Effective read latency
    logic [3:0]  eff_cwl;     // Effective write latency
    logic [3:0]  eff_al;      // Additive latency
    logic [4:0]  rd_lat;      // Edges from read to strobe
    logic        setup;       // APB setup phase
    logic        wr_acc;      // APB write taken

    // =====================================================
    // Pin synchronisation, every pin passes two flops
    ddl_sync u_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .async_i ({mem_clk_i, cke_i, termination_control_i,
                   cmd_i, ba_i, addr_i, wdata_i}),
        .sync_o  (pins)
    );
    assign {clk_s, cke_s, odt_s, cmd_s, ba_s, addr_s, wdat_s} = pins;

    // =====================================================
    // Latency decode
    always_comb
    begin
        loop_off = st.mr1[`DDL_MR1_LOOP_OFF];
        // Loop off forces both latencies to six
        if (loop_off)
        begin
            eff_cl  = `DDL_LAT_OFF;
            eff_cwl = `DDL_LAT_OFF;
        end
        else
        begin
            eff_cl  = `DDL_LAT_BASE
                      + {1'b0, st.mr0[`DDL_MR0_CL_LSB +: 3]};
            eff_cwl = `DDL_LAT_BASE
                      + {1'b0, st.mr2[`DDL_MR2_CWL_LSB +: 3]};
        end
        // Additive latency: off, CL-1 or CL-2
        unique case (st.mr1[`DDL_MR1_AL_LSB +: 2])
            2'b01:   eff_al = eff_cl - 4'h1;
            2'b10:   eff_al = eff_cl - 4'h2;
            default: eff_al = 4'h0;
        endcase
        // Strobe window one edge earlier with loop off
        rd_lat = {1'b0, eff_al} + {1'b0, eff_cl}
                 - {4'h0, loop_off};
    end

    assign edge_r = clk_s && !st.prev_clk;
    // Once clock is ignored, no edge reaches the logic
    assign live   = edge_r && !st.ign_clk;
    assign setup  = psel_i && !penable_i;
    assign wr_acc = psel_i && penable_i && pwrite_i;

    // =====================================================
    // Next-state logic
    always_comb
    begin
        next_st          = st;
        next_st.prev_clk = clk_s;
        // Power state sequencing
        unique case (st.state)
            DDL_IDLE:
            begin
                if (live && !cke_s)
                    next_st.state = DDL_PD;
                else if (live && cmd_s == `DDL_C_SRE)
                begin
                    next_st.state    = DDL_SR;
                    next_st.hold_cnt = st.cfg_hold;
                    next_st.rd_busy  = 1'b0;
                end
            end
            DDL_SR:
            begin
                // Count entry hold, then stop watching clock
                if (live && st.hold_cnt != 8'h00)
                    next_st.hold_cnt = st.hold_cnt - 8'h01;
                else if (st.hold_cnt == 8'h00)
                    next_st.ign_clk = 1'b1;
                // Exit needs no clock, only clock enable once the entry hold has run out
                if (cke_s && st.ign_clk)
                begin
                    next_st.state   = DDL_IDLE;
                    next_st.ign_clk = 1'b0;
                end
            end
            DDL_PD:
            begin
                if (live && cke_s)
                    next_st.state = DDL_IDLE;
            end
            default:
                next_st.state = DDL_IDLE;
        endcase
        // Commands act only in idle on a live edge
        if (st.state == DDL_IDLE && live && cke_s)
        begin
            unique case (cmd_s)
                `DDL_C_MRS:
                begin
                    if (ba_s == 2'h0)
                    begin
                        next_st.mr0 = addr_s;
                        next_st.mr0[`DDL_MR0_LOOP_RST] = 1'b0;
                        // Loop reset restarts the lock count only from zero; a running count keeps counting down
                        if (addr_s[`DDL_MR0_LOOP_RST])
                        begin
                            next_st.lock_cnt = `DDL_LOCK_CYC;
                            next_st.locked   = 1'b0;
                        end
                    end
                    else if (ba_s == 2'h1)
                        next_st.mr1 = addr_s;
                    else if (ba_s == 2'h2)
                        next_st.mr2 = addr_s;
                end
                `DDL_C_READ:
                begin
                    next_st.rd_busy = 1'b1;
                    next_st.rd_cnt  = rd_lat;
                end
                `DDL_C_WRITE:
                    next_st.stored = wdat_s;
                default:
                    next_st.stored = st.stored;
            endcase
        end
        // Read strobe countdown on command clock edges
        if (live && st.rd_busy && st.state == DDL_IDLE)
        begin
            if (st.rd_cnt <= 5'h01)
            begin
                next_st.rd_busy = 1'b0;
                next_st.dq_oe   = 1'b1;
                next_st.dq      = st.stored;
            end
            else
                next_st.rd_cnt = st.rd_cnt - 5'h01;
        end
        else if (live && st.dq_oe)
            next_st.dq_oe = 1'b0;
        // Lock counter advances on live edges
        if (live && st.lock_cnt != 10'h000)
        begin
            next_st.lock_cnt = st.lock_cnt - 10'h001;
            next_st.locked   = (st.lock_cnt == 10'h001);
        end
        // No termination with loop off or in self refresh
        next_st.term_on = odt_s && !loop_off && st.state != DDL_SR
                          && (st.mr1[`DDL_MR1_RTT_B2]
                              || st.mr1[`DDL_MR1_RTT_B1]
                              || st.mr1[`DDL_MR1_RTT_B0]);
        // APB read data captured in setup phase
        next_st.pslverr = 1'b0;
        if (setup)
        begin
            next_st.prdata = 32'h0;
            unique case (paddr_i)
                `DDL_A_STATUS: next_st.prdata =
                    {16'h0, eff_cwl, eff_cl, 3'h0, st.locked,
                     st.ign_clk, loop_off, st.state};
                `DDL_A_MODE0:  next_st.prdata = {19'h0, st.mr0};
                `DDL_A_MODE1:  next_st.prdata = {19'h0, st.mr1};
                `DDL_A_MODE2:  next_st.prdata = {19'h0, st.mr2};
                `DDL_A_CONFIG: next_st.prdata = {24'h0, st.cfg_hold};
                default:       next_st.pslverr = 1'b1;
            endcase
        end
        // APB write of the hold count
        if (wr_acc && paddr_i == `DDL_A_CONFIG)
            next_st.cfg_hold = pwdata_i[7:0];
        if (psel_i && penable_i)
            next_st.pslverr = st.pslverr;
    end

    // =====================================================
    // State register; stored data survive self refresh
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            st          <= '0;
            st.cfg_hold <= `DDL_HOLD_RST;
        end
        else
            st <= next_st;
    end

    assign dq_o      = st.dq;
    assign dq_oe_o   = st.dq_oe;
    assign term_on_o = st.term_on;
    assign state_o   = st.state;
    assign prdata_o  = st.prdata;
    assign pslverr_o = st.pslverr && psel_i && penable_i;
    assign pready_o  = 1'b1;

    // =====================================================
    // Checks
    logic [4:0] hx_edges;   // Live edges since read
    logic [4:0] hx_exp;     // Expected strobe edge count
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || (live && cmd_s == `DDL_C_READ
                        && st.state == DDL_IDLE && cke_s))
        begin
            hx_edges <= 5'h00;
            hx_exp   <= reset_i ? 5'h00 : rd_lat;
        end
        else if (live && st.rd_busy)
            hx_edges <= hx_edges + 5'h01;
    end

    sequence s_in_sr;
        st.state == DDL_SR;
    endsequence

    property p_retain;
        @(posedge mclk_i) disable iff (reset_i)
        s_in_sr ##1 s_in_sr |-> $stable(st.stored);
    endproperty
    a_retain: assert property (p_retain)
        else $error("Stored data changed in self refresh");

    property p_lat_off;
        @(posedge mclk_i) disable iff (reset_i)
        loop_off |-> eff_cl == 4'h6 && eff_cwl == 4'h6;
    endproperty
    a_lat_off: assert property (p_lat_off)
        else $error("Latency not six with loop off");

    property p_strobe;
        @(posedge mclk_i) disable iff (reset_i)
        $rose(st.dq_oe) |-> hx_edges == hx_exp
            || (hx_exp == 5'h00 && hx_edges == 5'h01);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("Read strobe at wrong edge");

    property p_ignore;
        @(posedge mclk_i) disable iff (reset_i)
        st.ign_clk && !cke_s && st.state == DDL_SR
            |=> st.state == DDL_SR && $stable(st.mr1)
                && $stable(st.mr0);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("Clock acted on after entry hold");
endmodule : ddl_top
`default_nettype wire
